// >>> src/umcs_pkg.sv
/*
  Shared constants for the serial mode and baud clock block: register
  indices, field positions, reset values, mode and state encodings.
  Assumes a 32-bit classic Wishbone bus with word-aligned registers.
*/
//
// Summary of operation
// - external clock pin divided by sixteen
// - external path gives MIDI rate from 500 kHz
// - three modes: stopped, UART, three-wire
// - stopped: no transfer, pins released
// - serial mode bit 7 enables three-wire
// - serial mode bit 1 picks shift clock
// - independent transmit and receive enables, full duplex
// - parity field: none, zero, odd, even
// - parity 01: send zero, never flag
// - bit 2 picks one or two stops
// - receiver checks first stop bit only
// - frame: start, 7/8 bits, parity, stop
// - reset clears both; byte writes only, bits by read-modify-write
package umcs_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ASYNC_LINE_MODE = 16'hff70;
  localparam logic [15:0] IDX_ERROR_FLAGS     = 16'hff71;
  localparam logic [15:0] IDX_SERIAL_OP_MODE  = 16'hff72;
  localparam logic [15:0] IDX_BAUD_SOURCE     = 16'hff73;
  localparam logic [15:0] IDX_TX_DATA         = 16'hff74;
  localparam logic [15:0] IDX_RX_DATA         = 16'hff75;
  localparam logic [15:0] IDX_STATUS          = 16'hff76;
  localparam logic [7:0]  REG_RESET           = 8'h00;
  // serial operation mode fields
  localparam int SOM_ENABLE = 7;
  localparam int SOM_ORDER  = 2;
  localparam int SOM_CLKSEL = 1;
  // async line mode fields
  localparam int ALM_TXE    = 7;
  localparam int ALM_RXE    = 6;
  localparam int ALM_PAR_HI = 5;
  localparam int ALM_PAR_LO = 4;
  localparam int ALM_CHAR8  = 3;
  localparam int ALM_STOP2  = 2;
  localparam logic [1:0] PAR_NONE = 2'b00;
  localparam logic [1:0] PAR_ZERO = 2'b01;
  localparam logic [1:0] PAR_ODD  = 2'b10;
  localparam logic [1:0] PAR_EVEN = 2'b11;
  // baud source: external pin, or system clock over 2^n with n = hi+1
  localparam logic [7:0] BRG_EXTERNAL = 8'h80;
  localparam int         BRG_N_LSB    = 4;
  localparam logic [3:0] TICK_LAST    = 4'hf;
  localparam logic [3:0] TICK_HALF    = 4'h7;
  localparam logic [2:0] LAST_BIT8    = 3'h7;
  localparam logic [2:0] LAST_BIT7    = 3'h6;
  localparam logic [3:0] SIO_EDGES    = 4'hf;

  typedef enum logic [2:0] {
    MODE_STOP = 3'b001,
    MODE_UART = 3'b010,
    MODE_3W   = 3'b100
  } umcs_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA  = 5'b00100,
    ST_PAR   = 5'b01000,
    ST_STOP  = 5'b10000
  } umcs_state_e;
endpackage

// >>> src/umcs_rx.sv
/*
  Asynchronous frame receiver: samples the line on a 16x tick enable,
  checks parity and the first stop bit.
  Assumes rxd is synchronous to clk and tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module umcs_rx
  import umcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       rxd,
  input  wire logic       char8,
  input  wire logic [1:0] par_mode,
  output logic            done,
  output logic [7:0]      data,
  output logic            perr,
  output logic            ferr
);
  umcs_state_e st;
  logic [3:0]  tcnt;
  logic [2:0]  bcnt;
  logic [7:0]  sh;
  logic        pacc;

  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (!nrst || !enable)
    begin
      st   <= ST_IDLE;
      tcnt <= 4'h0;
      bcnt <= 3'h0;
      sh   <= 8'h00;
      pacc <= 1'b0;
      data <= 8'h00;
      perr <= 1'b0;
      ferr <= 1'b0;
    end
    else if (tick)
    begin
      tcnt <= tcnt + 4'h1;
      case (st)
        ST_IDLE:
          if (!rxd)
          begin
            st   <= ST_START;
            tcnt <= 4'h0;
          end
        ST_START:
          if (tcnt == TICK_HALF)
          begin
            st   <= rxd ? ST_IDLE : ST_DATA;
            tcnt <= 4'h0;
            bcnt <= 3'h0;
            pacc <= 1'b0;
          end
        ST_DATA:
          if (tcnt == TICK_LAST)
          begin
            sh   <= {rxd, sh[7:1]};
            pacc <= pacc ^ rxd;
            bcnt <= bcnt + 3'h1;
            if (bcnt == (char8 ? LAST_BIT8 : LAST_BIT7))
              st <= (par_mode == PAR_NONE) ? ST_STOP : ST_PAR;
          end
        ST_PAR:
          if (tcnt == TICK_LAST)
          begin
            pacc <= pacc ^ rxd;
            st   <= ST_STOP;
          end
        ST_STOP:
          if (tcnt == TICK_LAST)
          begin
            // only the first stop bit is looked at
            st   <= ST_IDLE;
            done <= 1'b1;
            ferr <= !rxd;
            data <= char8 ? sh : {1'b0, sh[7:1]};
            case (par_mode)
              PAR_ODD:  perr <= !pacc;
              PAR_EVEN: perr <= pacc;
              default:  perr <= 1'b0;
            endcase
          end
        default: st <= ST_IDLE;
      endcase
    end
  end

  property p_rx_zero_par;
    @(posedge clk) disable iff (!nrst)
      (done && par_mode == PAR_ZERO) |-> !perr;
  endproperty
  a_rx_zero_par: assert property (p_rx_zero_par)
    else $error("parity error flagged with zero parity");

  property p_rx_first_stop;
    @(posedge clk) disable iff (!nrst)
      (enable && tick && st == ST_STOP && tcnt == TICK_LAST && rxd)
        |=> done && !ferr && st == ST_IDLE;
  endproperty
  a_rx_first_stop: assert property (p_rx_first_stop)
    else $error("frame not closed on first stop bit");
endmodule // umcs_rx
`default_nettype wire

// >>> src/umcs_top.sv
/*
  Serial unit mode control and baud clock: Wishbone registers, baud
  tick from system clock or external pin over 16, UART transmitter,
  three-wire shifter and pin ownership.
  Assumes a classic Wishbone master and pins synchronous to CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module umcs_top
  import umcs_pkg::*;
#(
  parameter int ADR_W = 18
)
(
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  wire logic [ADR_W-1:0] ADR_I,
  input  wire logic [31:0]      DAT_I,
  input  wire logic             WE_I,
  input  wire logic [3:0]       SEL_I,
  input  wire logic             CYC_I,
  input  wire logic             STB_I,
  output logic [31:0]           DAT_O,
  output logic                  ACK_O,
  input  wire logic             SERIAL_CLOCK_PIN_I,
  output logic                  SERIAL_CLOCK_PIN_O,
  output logic                  SERIAL_CLOCK_PIN_OE,
  output logic                  SERIAL_OUT_PIN_O,
  output logic                  SERIAL_OUT_PIN_OE,
  input  wire logic             SERIAL_IN_PIN_I
);
  // --------------------------------------------------------------
  // registers and decode
  // --------------------------------------------------------------
  logic [7:0]  async_line_mode;
  logic [7:0]  serial_operation_mode;
  logic [7:0]  baud_source_select_reg;
  logic [2:0]  async_error_flags;
  logic [7:0]  rx_data;
  logic        rx_full;
  logic [15:0] idx;
  logic        acc;
  logic        wr;
  logic        rd_rx;
  logic        wr_tx;

  assign idx   = ADR_I[ADR_W-1:2];
  assign acc   = CYC_I && STB_I && !ACK_O;
  assign wr    = acc && WE_I && SEL_I[0];
  assign rd_rx = acc && !WE_I && idx == IDX_RX_DATA;
  assign wr_tx = wr && idx == IDX_TX_DATA;

  logic       transmit_enable;
  logic       receive_enable;
  logic [1:0] par_mode;
  logic       three_wire_enable;
  logic       three_wire_clock_select;
  logic       shift_bit_order;
  umcs_mode_e mode;

  assign transmit_enable         = async_line_mode[ALM_TXE];
  assign receive_enable          = async_line_mode[ALM_RXE];
  assign par_mode = {async_line_mode[ALM_PAR_HI],
                     async_line_mode[ALM_PAR_LO]};
  assign three_wire_enable       = serial_operation_mode[SOM_ENABLE];
  assign three_wire_clock_select = serial_operation_mode[SOM_CLKSEL];
  assign shift_bit_order         = serial_operation_mode[SOM_ORDER];

  // three modes, three-wire has priority over UART enables
  always_comb
  begin
    if (three_wire_enable)
      mode = MODE_3W;
    else if (transmit_enable || receive_enable)
      mode = MODE_UART;
    else
      mode = MODE_STOP;
  end

  // single-bit updates are a read-modify-write of the low byte
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      async_line_mode        <= REG_RESET;
      serial_operation_mode  <= REG_RESET;
      baud_source_select_reg <= REG_RESET;
    end
    else if (wr)
    begin
      if (idx == IDX_ASYNC_LINE_MODE)
        async_line_mode <= DAT_I[7:0];
      else if (idx == IDX_SERIAL_OP_MODE)
        serial_operation_mode <= DAT_I[7:0];
      else if (idx == IDX_BAUD_SOURCE)
        baud_source_select_reg <= DAT_I[7:0];
    end
  end

  logic tx_busy;
  logic sio_busy;

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ACK_O <= acc;
      DAT_O <= 32'h0000_0000;
      if (acc && !WE_I)
      begin
        if (idx == IDX_ASYNC_LINE_MODE)
          DAT_O[7:0] <= async_line_mode;
        else if (idx == IDX_ERROR_FLAGS)
          DAT_O[2:0] <= async_error_flags;
        else if (idx == IDX_SERIAL_OP_MODE)
          DAT_O[7:0] <= serial_operation_mode;
        else if (idx == IDX_BAUD_SOURCE)
          DAT_O[7:0] <= baud_source_select_reg;
        else if (idx == IDX_RX_DATA)
          DAT_O[7:0] <= rx_data;
        else if (idx == IDX_STATUS)
          DAT_O[2:0] <= {sio_busy, rx_full, tx_busy};
      end
    end
  end

  // --------------------------------------------------------------
  // baud tick at sixteen times the bit rate
  // --------------------------------------------------------------
  logic       clk_pin_prev;
  logic [7:0] div_cnt;
  logic [7:0] div_mask;
  logic       ext_sel;
  logic       ext_rise;
  logic       tick16;

  assign ext_sel  = baud_source_select_reg == BRG_EXTERNAL;
  assign ext_rise = SERIAL_CLOCK_PIN_I && !clk_pin_prev;
  // internal: 2^n system clocks per tick, n = field + 1
  assign div_mask = 8'hff >> (3'h7 - baud_source_select_reg[6:4]);
  // external: every pin rising edge is one tick, so rate = pin / 16
  assign tick16   = ext_sel ? ext_rise
                  : ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      clk_pin_prev <= 1'b1;
      div_cnt      <= 8'h00;
    end
    else
    begin
      clk_pin_prev <= SERIAL_CLOCK_PIN_I;
      div_cnt      <= div_cnt + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // UART transmitter
  // --------------------------------------------------------------
  umcs_state_e tx_st;
  logic [3:0]  tx_tcnt;
  logic [2:0]  tx_bcnt;
  logic [7:0]  tx_sh;
  logic        tx_par;
  logic        tx_line;
  logic        uart_tx_on;
  logic        char8;
  logic        stop2;

  assign uart_tx_on = mode == MODE_UART && transmit_enable;
  assign char8      = async_line_mode[ALM_CHAR8];
  assign stop2      = async_line_mode[ALM_STOP2];
  assign tx_busy    = tx_st != ST_IDLE;

  always_ff @(posedge CLK)
  begin
    if (!NRST || !uart_tx_on)
    begin
      tx_st   <= ST_IDLE;
      tx_tcnt <= 4'h0;
      tx_bcnt <= 3'h0;
      tx_sh   <= 8'h00;
      tx_par  <= 1'b0;
      tx_line <= 1'b1;
    end
    else if (tx_st == ST_IDLE)
    begin
      if (wr_tx)
      begin
        tx_st   <= ST_START;
        tx_sh   <= char8 ? DAT_I[7:0] : {1'b0, DAT_I[6:0]};
        tx_par  <= 1'b0;
        tx_tcnt <= 4'h0;
        tx_bcnt <= 3'h0;
        tx_line <= 1'b0;
      end
    end
    else if (tick16)
    begin
      tx_tcnt <= tx_tcnt + 4'h1;
      if (tx_tcnt == TICK_LAST)
      begin
        case (tx_st)
          ST_START:
          begin
            tx_st   <= ST_DATA;
            tx_line <= tx_sh[0];
          end
          ST_DATA:
          begin
            tx_par  <= tx_par ^ tx_sh[0];
            tx_sh   <= {1'b0, tx_sh[7:1]};
            tx_bcnt <= tx_bcnt + 3'h1;
            if (tx_bcnt == (char8 ? LAST_BIT8 : LAST_BIT7))
            begin
              tx_bcnt <= 3'h0;
              if (par_mode == PAR_NONE)
              begin
                tx_st   <= ST_STOP;
                tx_line <= 1'b1;
              end
              else
              begin
                tx_st <= ST_PAR;
                case (par_mode)
                  PAR_ODD:  tx_line <= !(tx_par ^ tx_sh[0]);
                  PAR_EVEN: tx_line <= tx_par ^ tx_sh[0];
                  default:  tx_line <= 1'b0;
                endcase
              end
            end
            else
              tx_line <= tx_sh[1];
          end
          ST_PAR:
          begin
            tx_st   <= ST_STOP;
            tx_line <= 1'b1;
          end
          ST_STOP:
            if (stop2 && tx_bcnt == 3'h0)
              tx_bcnt <= 3'h1;
            else
              tx_st <= ST_IDLE;
          default: tx_st <= ST_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // UART receiver and error flags
  // --------------------------------------------------------------
  logic       rx_done;
  logic [7:0] rx_byte;
  logic       rx_perr;
  logic       rx_ferr;

  umcs_rx u_rx (
    .clk      (CLK),
    .nrst     (NRST),
    .tick     (tick16),
    .enable   (mode == MODE_UART && receive_enable),
    .rxd      (SERIAL_IN_PIN_I),
    .char8    (char8),
    .par_mode (par_mode),
    .done     (rx_done),
    .data     (rx_byte),
    .perr     (rx_perr),
    .ferr     (rx_ferr)
  );

  // --------------------------------------------------------------
  // three-wire shifter
  // --------------------------------------------------------------
  logic [7:0] sio_sh;
  logic [3:0] sio_cnt;
  logic       sio_clk;
  logic       sio_bit;
  logic       sio_fall;
  logic       sio_rise;
  logic       sio_done;

  // clock from pin edges, or internal ticks toggling the driven clock
  assign sio_fall = three_wire_clock_select ? (tick16 && sio_clk)
                  : (!SERIAL_CLOCK_PIN_I && clk_pin_prev);
  assign sio_rise = three_wire_clock_select ? (tick16 && !sio_clk)
                  : ext_rise;

  always_ff @(posedge CLK)
  begin
    sio_done <= 1'b0;
    if (!NRST || mode != MODE_3W)
    begin
      sio_busy <= 1'b0;
      sio_sh   <= 8'h00;
      sio_cnt  <= 4'h0;
      sio_clk  <= 1'b1;
      sio_bit  <= 1'b1;
    end
    else if (!sio_busy)
    begin
      if (wr_tx)
      begin
        sio_busy <= 1'b1;
        sio_cnt  <= 4'h0;
        sio_sh   <= DAT_I[7:0];
        sio_bit  <= shift_bit_order ? DAT_I[0] : DAT_I[7];
      end
    end
    else if (sio_fall)
    begin
      sio_clk <= 1'b0;
      sio_cnt <= sio_cnt + 4'h1;
      if (sio_cnt != 4'h0)
        sio_bit <= shift_bit_order ? sio_sh[0] : sio_sh[7];
    end
    else if (sio_rise && sio_cnt != 4'h0)
    begin
      sio_clk <= 1'b1;
      sio_cnt <= sio_cnt + 4'h1;
      if (shift_bit_order)
        sio_sh <= {SERIAL_IN_PIN_I, sio_sh[7:1]};
      else
        sio_sh <= {sio_sh[6:0], SERIAL_IN_PIN_I};
      if (sio_cnt == SIO_EDGES)
      begin
        sio_busy <= 1'b0;
        sio_done <= 1'b1;
      end
    end
  end

  // receive buffer shared by both modes; reading it empties it
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      rx_data           <= 8'h00;
      rx_full           <= 1'b0;
      async_error_flags <= 3'b000;
    end
    else if (rx_done)
    begin
      rx_data           <= rx_byte;
      rx_full           <= 1'b1;
      async_error_flags <= {rx_perr, rx_ferr, rx_full};
    end
    else if (sio_done)
    begin
      rx_data <= sio_sh;
      rx_full <= 1'b1;
    end
    else if (rd_rx)
      rx_full <= 1'b0;
  end

  // --------------------------------------------------------------
  // pin ownership
  // --------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      SERIAL_OUT_PIN_O    <= 1'b1;
      SERIAL_OUT_PIN_OE   <= 1'b0;
      SERIAL_CLOCK_PIN_O  <= 1'b1;
      SERIAL_CLOCK_PIN_OE <= 1'b0;
    end
    else
    begin
      case (mode)
        MODE_UART:
        begin
          SERIAL_OUT_PIN_O    <= tx_line;
          SERIAL_OUT_PIN_OE   <= transmit_enable;
          SERIAL_CLOCK_PIN_O  <= 1'b1;
          SERIAL_CLOCK_PIN_OE <= 1'b0;
        end
        MODE_3W:
        begin
          SERIAL_OUT_PIN_O    <= sio_bit;
          SERIAL_OUT_PIN_OE   <= 1'b1;
          SERIAL_CLOCK_PIN_O  <= sio_clk;
          SERIAL_CLOCK_PIN_OE <= three_wire_clock_select;
        end
        default:
        begin
          SERIAL_OUT_PIN_O    <= 1'b1;
          SERIAL_OUT_PIN_OE   <= 1'b0;
          SERIAL_CLOCK_PIN_O  <= 1'b1;
          SERIAL_CLOCK_PIN_OE <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_ext_tick;
    @(posedge CLK) disable iff (!NRST)
      ext_sel |-> (tick16 == (SERIAL_CLOCK_PIN_I
                              && !$past(SERIAL_CLOCK_PIN_I)));
  endproperty
  a_ext_tick: assert property (p_ext_tick)
    else $error("external tick not one per pin rising edge");

  property p_stop_release;
    @(posedge CLK) disable iff (!NRST)
      mode == MODE_STOP |=> !SERIAL_OUT_PIN_OE && !SERIAL_CLOCK_PIN_OE;
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("pins driven in stopped mode");

  property p_sio_off;
    @(posedge CLK) disable iff (!NRST)
      !three_wire_enable |=> !sio_busy;
  endproperty
  a_sio_off: assert property (p_sio_off)
    else $error("shifter busy with three-wire disabled");

  property p_sio_ext_clk;
    @(posedge CLK) disable iff (!NRST)
      (mode == MODE_3W && !three_wire_clock_select)
        |=> !SERIAL_CLOCK_PIN_OE;
  endproperty
  a_sio_ext_clk: assert property (p_sio_ext_clk)
    else $error("clock pin driven with external shift clock");

  property p_tx_off;
    @(posedge CLK) disable iff (!NRST)
      !transmit_enable |=> tx_st == ST_IDLE && tx_line;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("transmitter active while disabled");

  property p_zero_par;
    @(posedge CLK) disable iff (!NRST)
      (tx_st == ST_PAR && par_mode == PAR_ZERO) |-> !tx_line;
  endproperty
  a_zero_par: assert property (p_zero_par)
    else $error("zero parity bit not low");

  property p_two_stop;
    @(posedge CLK) disable iff (!NRST)
      (uart_tx_on && tick16 && tx_st == ST_STOP && tx_tcnt == TICK_LAST
        && stop2 && tx_bcnt == 3'h0) |=> tx_st == ST_STOP && tx_line;
  endproperty
  a_two_stop: assert property (p_two_stop)
    else $error("second stop bit missing");

  property p_som_write;
    @(posedge CLK) disable iff (!NRST)
      (wr && idx == IDX_SERIAL_OP_MODE)
        ##1 ACK_O |-> serial_operation_mode == $past(DAT_I[7:0]);
  endproperty
  a_som_write: assert property (p_som_write)
    else $error("serial mode byte write lost");
endmodule // umcs_top
`default_nettype wire

// >>> verif/umcs_peer.sv
/*
  Far-end asynchronous transmitter and receiver model.
  Assumes a fixed bit time in clk cycles and an idle-high line.
*/
`timescale 1ns/1ps
`default_nettype none
module umcs_peer
#(
  parameter int BIT_CYC = 32
)
(
  input  wire logic clk,
  input  wire logic line_in,
  output logic      txd
);
  initial txd = 1'h1;

  task automatic put(input logic b);
    txd <= b;
    repeat (BIT_CYC) @(posedge clk);
  endtask

  task automatic smp(output logic b);
    repeat (BIT_CYC) @(posedge clk);
    b = line_in;
  endtask

  // start, lsb-first character, optional parity, stop bits
  task automatic send(input logic [7:0] d, input logic c8,
    input logic hp, input logic pb, input logic [1:0] st,
    input logic s2);
    put(1'h0);
    for (int i = 0; i < 7 + c8; i++)
      put(d[i]);
    if (hp)
      put(pb);
    put(st[0]);
    if (s2)
      put(st[1]);
    txd <= 1'h1;
  endtask

  // samples mid-bit, returns in the middle of the first stop bit
  task automatic recv(input logic c8, input logic hp,
    output logic [7:0] d, output logic pb, output logic sb);
    d = 8'h00;
    pb = 1'h0;
    while (line_in !== 1'h0) @(posedge clk);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 7 + c8; i++)
      smp(d[i]);
    if (hp)
      smp(pb);
    smp(sb);
  endtask
endmodule // umcs_peer
`default_nettype wire

// >>> verif/umcs_top_tb.sv
/*
  Self-checking bench: registers, UART frames both ways, external
  baud clock and three-wire shifts.
  Assumes umcs_pkg, umcs_top and the umcs_peer far-end model.
*/
`timescale 1ns/1ps
`default_nettype none
module umcs_top_tb
  import umcs_pkg::*;
();
  logic        clk = 1'h0;
  logic        nrst = 1'h0;
  logic [17:0] adr = 18'h0_0000;
  logic [31:0] dat = 32'h0000_0000;
  logic        wen = 1'h0;
  logic [3:0]  sel = 4'h0;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        ext = 1'h1;
  logic        lp = 1'h0;
  logic [7:0]  r, st, d, e, v, rd, cap, dr;
  logic [1:0]  pm;
  logic        c8, s2, rp, rs, bad, fe;
  int          ext_per = 0, ncap = 0, n, cyc_n = 0, seed = 32'h1baf;
  int          fails = 0, check_count = 0;
  wire logic [31:0] dat_o;
  wire logic   ack, sck_o, sck_oe, so_o, so_oe, txd, sck_w, so_w;

  // released pins: clock pin from the bench, out pin pulled up
  assign sck_w = sck_oe ? sck_o : ext;
  assign so_w = so_oe ? so_o : 1'h1;

  umcs_top #(.ADR_W(18)) uut
  (
    .CLK(clk), .NRST(nrst), .ADR_I(adr), .DAT_I(dat), .WE_I(wen),
    .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_o), .ACK_O(ack),
    .SERIAL_CLOCK_PIN_I(sck_w), .SERIAL_CLOCK_PIN_O(sck_o),
    .SERIAL_CLOCK_PIN_OE(sck_oe), .SERIAL_OUT_PIN_O(so_o),
    .SERIAL_OUT_PIN_OE(so_oe), .SERIAL_IN_PIN_I(lp ? so_w : txd)
  );
  umcs_peer #(.BIT_CYC(32)) peer
  (
    .clk(clk), .line_in(so_w), .txd(txd)
  );

  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000)
    begin
      fails = fails + 1;
      results();
    end
  end

  // free-running external baud clock while ext_per is set
  always
  begin
    @(posedge clk);
    if (ext_per > 0)
    begin
      repeat (ext_per / 2 - 1) @(posedge clk);
      ext <= 1'h0;
      repeat (ext_per / 2) @(posedge clk);
      ext <= 1'h1;
    end
  end

  always @(posedge sck_w)
    if (ncap < 8)
    begin
      cap <= {cap[6:0], so_w};
      ncap <= ncap + 1;
    end

  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [15:0] idx,
    input logic [7:0] wd, input logic [3:0] s, output logic [7:0] q);
    @(posedge clk);
    adr <= {idx, 2'h0};
    dat <= {24'h00_0000, wd};
    wen <= w;
    sel <= s;
    cyc <= 1'h1;
    stb <= 1'h1;
    do @(posedge clk); while (ack !== 1'h1);
    q = dat_o[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    wb(1'h1, idx, wd, 4'hf, r);
  endtask

  task automatic rc(input string nm, input logic [15:0] idx,
    input logic [7:0] exp);
    wb(1'h0, idx, 8'h00, 4'hf, r);
    chk(nm, {8'h00, r}, {8'h00, exp});
  endtask

  function automatic logic pbit(input logic [7:0] x, input logic w8,
    input logic [1:0] m);
    logic o;
    o = ^(x & {w8, 7'h7f});
    return (m == PAR_ODD) ? ~o : (m == PAR_EVEN) ? o : 1'h0;
  endfunction

  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    rc("alm_rst", IDX_ASYNC_LINE_MODE, REG_RESET);
    rc("som_rst", IDX_SERIAL_OP_MODE, REG_RESET);
    rc("unmapped", 16'hff7f, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed)) & 8'hfc;
      wr(IDX_ASYNC_LINE_MODE, v);
      wb(1'h1, IDX_ASYNC_LINE_MODE, ~v, 4'he, r);
      rc("alm_rw", IDX_ASYNC_LINE_MODE, v);
      wr(IDX_SERIAL_OP_MODE, v & 8'h86);
      rc("som_rw", IDX_SERIAL_OP_MODE, v & 8'h86);
      chk("mode_oe", {sck_oe, so_oe}, {v[7] & v[1], v[7]});
      wr(IDX_SERIAL_OP_MODE, 8'h00);
      wr(IDX_ASYNC_LINE_MODE, 8'h00);
    end
    wr(IDX_BAUD_SOURCE, 8'h00);
    chk("stop_oe", {sck_oe, so_oe}, 16'h0000);
    // every parity, length and stop setting, both directions at once
    for (int k = 0; k < 16; k++)
    begin
      pm = k[3:2];
      c8 = k[1];
      s2 = k[0];
      wr(IDX_ASYNC_LINE_MODE, {2'h3, pm, c8, s2, 2'h0});
      d = 8'($random(seed));
      e = 8'($random(seed));
      {bad, fe} = 2'($random(seed));
      fe = fe & ~s2;
      fork
        peer.send(e, c8, pm != 2'h0, pbit(e, c8, pm) ^ bad, {1'h0, ~fe}, s2);
        wr(IDX_TX_DATA, d);
        begin
          peer.recv(c8, pm != 2'h0, rd, rp, rs);
          repeat (30) @(posedge clk);
          wb(1'h0, IDX_STATUS, 8'h00, 4'hf, st);
        end
      join
      chk("uart_oe", {sck_oe, so_oe}, 16'h0001);
      chk("tx_data", {8'h00, rd}, {8'h00, d & {c8, 7'h7f}});
      chk("tx_par", {15'h0, rp}, {15'h0, pbit(d, c8, pm)});
      chk("tx_stop", {rs, st[0]}, {1'h1, s2});
      rc("rx_flags", IDX_ERROR_FLAGS, {5'h00, bad & pm[1], fe, 1'h0});
      rc("rx_data", IDX_RX_DATA, e & {c8, 7'h7f});
      repeat (520) @(posedge clk);
      wb(1'h0, IDX_RX_DATA, 8'h00, 4'hf, r);
    end
    // external pin over sixteen, system clock over four, mid-frame reset
    for (int j = 0; j < 3; j++)
    begin
      ext_per = (j == 1) ? 500 : (j == 0) ? 8 : 0;
      wr(IDX_BAUD_SOURCE, (j == 2) ? 8'h10 : BRG_EXTERNAL);
      wr(IDX_ASYNC_LINE_MODE, 8'h88);
      wr(IDX_TX_DATA, 8'h01);
      while (so_w !== 1'h0) @(posedge clk);
      while (so_w !== 1'h1) @(posedge clk);
      for (n = 0; so_w === 1'h1; n++) @(posedge clk);
      chk("ext_bit", 16'(n),
        (j == 2) ? 16'h0040 : 16'(16 * ext_per));
      // let the pin generator finish its period so the pin idles high
      ext_per = 0;
      repeat (500) @(posedge clk);
      nrst <= 1'h0;
      @(posedge clk);
      nrst <= 1'h1;
      rc("alm_rst2", IDX_ASYNC_LINE_MODE, REG_RESET);
      chk("rst_oe", {sck_oe, so_oe}, 16'h0000);
    end
    // three-wire loopback, both clocks and both bit orders
    lp = 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_SERIAL_OP_MODE, {1'h1, 4'h0, k[1], ~k[0], 1'h0});
      d = 8'($random(seed));
      dr = {<<{d}};
      ncap = 0;
      wr(IDX_TX_DATA, d);
      if (k[0])
        repeat (16)
        begin
          repeat (8) @(posedge clk);
          ext <= ~ext;
        end
      while (ncap < 8) @(posedge clk);
      repeat (8) @(posedge clk);
      chk("sio_out", {8'h00, cap}, {8'h00, k[1] ? dr : d});
      rc("sio_in", IDX_RX_DATA, d);
      chk("sio_oe", {sck_oe, so_oe}, {~k[0], 1'h1});
      wr(IDX_SERIAL_OP_MODE, 8'h00);
    end
    results();
  end
endmodule // umcs_top_tb
`default_nettype wire
